// file: hw/ncs_nvm_config_sequencer.sv
`timescale 1ns/100ps

module ncs_nvm_config_sequencer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [4:0] powerUpConditionPins,
  output logic mapWrEn,
  output logic mapRdEn,
  output logic [ncs_pkg::MAP_AW-1:0] mapAddr,
  output logic [7:0] mapWrData,
  input wire logic [7:0] mapRdData,
  output logic ioUpdatePulse,
  output logic calStartPulse,
  output logic distSyncPulse,
  output logic busy
);
  import ncs_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] nvm_r [NVM_BYTES];
  logic [7:0] scratch_r [SP_BYTES];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ncs_state_e state_r, state_nxt;
  logic modeUp_r, modeUp_nxt;
  logic [SP_AW-1:0] spPtr_r, spPtr_nxt;
  logic [NVM_AW-1:0] memPtr_r, memPtr_nxt;
  logic [6:0] count_r, count_nxt;
  logic [15:0] xferAddr_r, xferAddr_nxt;
  logic [7:0] csum_r, csum_nxt;
  logic exec_r, exec_nxt;
  logic allOk_r, allOk_nxt;
  logic [31:0] tagBoard_r, tagBoard_nxt;
  logic done_r, done_nxt;
  logic fault_r, fault_nxt;
  logic wrEnable_r;
  logic [4:0] condReg_r;
  logic [7:0] regRdData_r;
  logic mapWrEn_r, mapWrEn_nxt;
  logic mapRdEn_r, mapRdEn_nxt;
  logic [15:0] mapAddr_r, mapAddr_nxt;
  logic [7:0] mapWrData_r, mapWrData_nxt;
  logic ioUpd_r, ioUpd_nxt;
  logic calStart_r, calStart_nxt;
  logic distSync_r, distSync_nxt;
  logic busy_r;
  logic memWe;
  logic [NVM_AW-1:0] memWaddr;
  logic [7:0] memWdata;

  // ----------------------------------------------------------------
  // Pin synchroniser and power-up latch
  // ----------------------------------------------------------------
  logic [4:0] pinMeta_r, pinSync2_r, pinSync3_r;
  logic [4:0] latchedPinSetting_r;
  logic [1:0] settleCnt_r;
  logic pinsLatched_r;
  logic bootStart_r;

  wire pinsSettled = (settleCnt_r == PIN_SETTLE_CYCLES) && (pinSync2_r == pinSync3_r);
  wire catchPins = settleCnt_r == PIN_SETTLE_CYCLES && !pinsLatched_r && pinsSettled;

  always_ff @(posedge sys_clk) begin
    pinMeta_r <= powerUpConditionPins;
    pinSync2_r <= pinMeta_r;
    pinSync3_r <= pinSync2_r;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      settleCnt_r <= 2'h0;
      pinsLatched_r <= 1'b0;
      latchedPinSetting_r <= 5'h00;
      bootStart_r <= 1'b0;
    end else begin
      if (settleCnt_r != PIN_SETTLE_CYCLES) settleCnt_r <= settleCnt_r + 2'h1;
      bootStart_r <= catchPins && (pinSync3_r != 5'h00);
      if (catchPins) begin
        pinsLatched_r <= 1'b1;
        latchedPinSetting_r <= pinSync3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire [15:0] spOfs = regAddr - OFS_SP_FIRST;
  wire [SP_AW-1:0] spWrIdx = spOfs[SP_AW-1:0];
  wire spHit = (regAddr >= OFS_SP_FIRST) && (regAddr <= OFS_SP_LAST);
  wire spWr = regWrEn && spHit;
  wire idle = state_r == ST_IDLE;
  wire saveCmd = regWrEn && regAddr == OFS_SAVE && regWrData[BIT_SAVE] && wrEnable_r;
  wire loadCmd = regWrEn && regAddr == OFS_LOAD && regWrData[BIT_LOAD];
  wire startUp = idle && saveCmd;
  wire startDown = idle && !saveCmd && (loadCmd || bootStart_r);
  wire [7:0] statusVal = {5'h00, busy_r, fault_r, done_r};
  wire [7:0] rdMux =
    (regAddr == OFS_STATUS) ? statusVal :
    (regAddr == OFS_WR_ENABLE) ? {7'h00, wrEnable_r} :
    (regAddr == OFS_CONDITION) ? {3'h0, condReg_r} :
    spHit ? scratch_r[spWrIdx] :
    8'h00;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrEnable_r <= 1'b0;
      condReg_r <= RST_CONDITION;
      regRdData_r <= 8'h00;
    end else begin
      if (regWrEn && regAddr == OFS_WR_ENABLE) wrEnable_r <= regWrData[BIT_WR_ENABLE];
      if (regWrEn && regAddr == OFS_CONDITION) condReg_r <= regWrData[4:0];
      if (regRdEn) regRdData_r <= rdMux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < SP_BYTES; i++) scratch_r[i] <= RST_SP_BYTE;
    end else if (spWr) begin
      scratch_r[spWrIdx] <= regWrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) nvm_r[memWaddr] <= memWdata;
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire spEnd = spPtr_r == SP_AW'(SP_BYTES);
  wire [7:0] curByte = modeUp_r ? (spEnd ? OP_PAUSE : scratch_r[spPtr_r]) : nvm_r[memPtr_r];
  wire isData = curByte <= OP_DATA_LAST;
  wire isCond = curByte >= OP_COND_NULL && curByte <= OP_COND_LAST;
  wire [7:0] condOfs = curByte - OP_COND_NULL;
  wire [4:0] condNum = condOfs[4:0];
  wire [4:0] activeCond = (condReg_r != 5'h00) ? condReg_r : latchedPinSetting_r;
  wire canExec = activeCond == 5'h00 || tagBoard_r == 32'h0 || tagBoard_r[activeCond];
  wire [NVM_AW-1:0] memPtrInc = memPtr_r + NVM_AW'(1);
  wire [SP_AW-1:0] spPtrInc = spPtr_r + SP_AW'(1);
  wire [7:0] csumAdd = csum_r + curByte;
  wire [7:0] csumAddMap = csum_r + mapRdData;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    modeUp_nxt = modeUp_r;
    spPtr_nxt = spPtr_r;
    memPtr_nxt = memPtr_r;
    count_nxt = count_r;
    xferAddr_nxt = xferAddr_r;
    csum_nxt = csum_r;
    exec_nxt = exec_r;
    allOk_nxt = allOk_r;
    tagBoard_nxt = tagBoard_r;
    done_nxt = done_r;
    fault_nxt = fault_r;
    mapWrEn_nxt = 1'b0;
    mapRdEn_nxt = 1'b0;
    mapAddr_nxt = mapAddr_r;
    mapWrData_nxt = mapWrData_r;
    ioUpd_nxt = 1'b0;
    calStart_nxt = 1'b0;
    distSync_nxt = 1'b0;
    memWe = 1'b0;
    memWaddr = memPtr_r;
    memWdata = curByte;
    case (state_r)
      ST_IDLE: begin
        if (startUp) begin
          modeUp_nxt = 1'b1;
          state_nxt = ST_FETCH;
        end else if (startDown) begin
          modeUp_nxt = 1'b0;
          memPtr_nxt = '0;
          tagBoard_nxt = 32'h0;
          allOk_nxt = 1'b1;
          done_nxt = 1'b0;
          fault_nxt = 1'b0;
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (modeUp_r) begin
          if (curByte == OP_PAUSE) begin
            spPtr_nxt = '0;
            state_nxt = ST_IDLE;
          end else if (curByte == OP_END) begin
            memWe = 1'b1;
            spPtr_nxt = '0;
            memPtr_nxt = '0;
            state_nxt = ST_IDLE;
          end else begin
            memWe = 1'b1;
            memPtr_nxt = memPtrInc;
            spPtr_nxt = spPtrInc;
            if (isData) begin
              count_nxt = curByte[6:0];
              state_nxt = ST_ADDRH;
            end
          end
        end else begin
          memPtr_nxt = memPtrInc;
          if (curByte == OP_END) begin
            memPtr_nxt = '0;
            done_nxt = allOk_r;
            state_nxt = ST_IDLE;
          end else if (isCond) begin
            if (condNum == 5'h00) tagBoard_nxt = 32'h0;
            else tagBoard_nxt[condNum] = 1'b1;
          end else if (isData) begin
            count_nxt = curByte[6:0];
            exec_nxt = canExec;
            state_nxt = ST_ADDRH;
          end else if (canExec) begin
            ioUpd_nxt = curByte == OP_IO_UPDATE;
            calStart_nxt = curByte == OP_CALIBRATE;
            distSync_nxt = curByte == OP_DIST_SYNC;
          end
        end
      end
      ST_ADDRH, ST_ADDRL: begin
        memWe = modeUp_r;
        memPtr_nxt = memPtrInc;
        if (modeUp_r) spPtr_nxt = spPtrInc;
        if (state_r == ST_ADDRH) begin
          xferAddr_nxt = {curByte, xferAddr_r[7:0]};
          state_nxt = ST_ADDRL;
        end else begin
          xferAddr_nxt = {xferAddr_r[15:8], curByte};
          csum_nxt = 8'h00;
          state_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        mapAddr_nxt = xferAddr_r;
        if (modeUp_r) begin
          mapRdEn_nxt = 1'b1;
          state_nxt = ST_WAIT;
        end else begin
          mapWrEn_nxt = exec_r;
          mapWrData_nxt = curByte;
          csum_nxt = csumAdd;
          memPtr_nxt = memPtrInc;
          xferAddr_nxt = xferAddr_r + 16'h0001;
          count_nxt = count_r - 7'h01;
          if (count_r == 7'h00) state_nxt = ST_CSUM;
        end
      end
      ST_WAIT: begin
        state_nxt = ST_CAP;
      end
      ST_CAP: begin
        memWe = 1'b1;
        memWdata = mapRdData;
        csum_nxt = csumAddMap;
        memPtr_nxt = memPtrInc;
        xferAddr_nxt = xferAddr_r + 16'h0001;
        count_nxt = count_r - 7'h01;
        state_nxt = (count_r == 7'h00) ? ST_CSUM : ST_XFER;
      end
      ST_CSUM: begin
        memPtr_nxt = memPtrInc;
        state_nxt = ST_FETCH;
        if (modeUp_r) begin
          memWe = 1'b1;
          memWdata = csum_r;
        end else if (exec_r && curByte != csum_r) begin
          fault_nxt = 1'b1;
          allOk_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      modeUp_r <= 1'b0;
      spPtr_r <= '0;
      memPtr_r <= '0;
      count_r <= 7'h00;
      xferAddr_r <= 16'h0000;
      csum_r <= 8'h00;
      exec_r <= 1'b0;
      allOk_r <= 1'b0;
      tagBoard_r <= 32'h0;
      done_r <= RST_STATUS[BIT_DONE];
      fault_r <= RST_STATUS[BIT_FAULT];
    end else begin
      state_r <= state_nxt;
      modeUp_r <= modeUp_nxt;
      spPtr_r <= spPtr_nxt;
      memPtr_r <= memPtr_nxt;
      count_r <= count_nxt;
      xferAddr_r <= xferAddr_nxt;
      csum_r <= csum_nxt;
      exec_r <= exec_nxt;
      allOk_r <= allOk_nxt;
      tagBoard_r <= tagBoard_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mapWrEn_r <= 1'b0;
      mapRdEn_r <= 1'b0;
      mapAddr_r <= 16'h0000;
      mapWrData_r <= 8'h00;
      ioUpd_r <= 1'b0;
      calStart_r <= 1'b0;
      distSync_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      mapWrEn_r <= mapWrEn_nxt;
      mapRdEn_r <= mapRdEn_nxt;
      mapAddr_r <= mapAddr_nxt;
      mapWrData_r <= mapWrData_nxt;
      ioUpd_r <= ioUpd_nxt;
      calStart_r <= calStart_nxt;
      distSync_r <= distSync_nxt;
      busy_r <= state_nxt != ST_IDLE;
    end
  end

  assign regRdData = regRdData_r;
  assign mapWrEn = mapWrEn_r;
  assign mapRdEn = mapRdEn_r;
  assign mapAddr = mapAddr_r;
  assign mapWrData = mapWrData_r;
  assign ioUpdatePulse = ioUpd_r;
  assign calStartPulse = calStart_r;
  assign distSyncPulse = distSync_r;
  assign busy = busy_r;

endmodule : ncs_nvm_config_sequencer

// file: hw/ncs_pkg.sv
package ncs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NVM_BYTES = 2048;
  localparam int unsigned NVM_AW = 11;
  localparam int unsigned SP_BYTES = 48;
  localparam int unsigned SP_AW = 6;
  localparam int unsigned MAP_AW = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_STATUS = 16'h0d03;
  localparam logic [15:0] OFS_WR_ENABLE = 16'h0e00;
  localparam logic [15:0] OFS_CONDITION = 16'h0e01;
  localparam logic [15:0] OFS_SAVE = 16'h0e02;
  localparam logic [15:0] OFS_LOAD = 16'h0e03;
  localparam logic [15:0] OFS_SP_FIRST = 16'h0e10;
  localparam logic [15:0] OFS_SP_LAST = 16'h0e3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_WR_ENABLE = 0;
  localparam int unsigned BIT_SAVE = 0;
  localparam int unsigned BIT_LOAD = 1;
  localparam int unsigned BIT_DONE = 0;
  localparam int unsigned BIT_FAULT = 1;
  localparam int unsigned BIT_BUSY = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SP_BYTE = 8'hff;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [4:0] RST_CONDITION = 5'h00;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DATA_LAST = 8'h7f;
  localparam logic [7:0] OP_IO_UPDATE = 8'h80;
  localparam logic [7:0] OP_CALIBRATE = 8'ha0;
  localparam logic [7:0] OP_DIST_SYNC = 8'ha1;
  localparam logic [7:0] OP_COND_NULL = 8'hb0;
  localparam logic [7:0] OP_COND_LAST = 8'hcf;
  localparam logic [7:0] OP_PAUSE = 8'hfe;
  localparam logic [7:0] OP_END = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_SETTLE_CYCLES = 2'h3;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b00000001,
    ST_FETCH = 8'b00000010,
    ST_ADDRH = 8'b00000100,
    ST_ADDRL = 8'b00001000,
    ST_XFER  = 8'b00010000,
    ST_WAIT  = 8'b00100000,
    ST_CAP   = 8'b01000000,
    ST_CSUM  = 8'b10000000
  } ncs_state_e;

endpackage : ncs_pkg

// file: testbench/ncs_map_model.sv
`timescale 1ns/100ps

module ncs_map_model (
  input wire logic sys_clk,
  input wire logic mapWrEn,
  input wire logic mapRdEn,
  input wire logic [ncs_pkg::MAP_AW-1:0] mapAddr,
  input wire logic [7:0] mapWrData,
  output logic [7:0] mapRdData
);
  import ncs_pkg::*;

  logic [7:0] mem [0:255];

  initial mapRdData = 8'h00;

  // Read data valid one cycle after request, scrambled otherwise
  always @(posedge sys_clk) begin
    if (mapWrEn) begin
      mem[mapAddr[7:0]] <= mapWrData;
    end
    if (mapRdEn) begin
      mapRdData <= mem[mapAddr[7:0]];
    end else begin
      mapRdData <= ~mapRdData;
    end
  end

endmodule : ncs_map_model

// file: testbench/ncs_seq_monitor.sv
`timescale 1ns/100ps

module ncs_seq_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic regWrEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic mapWrEn,
  input wire logic mapRdEn,
  input wire logic [ncs_pkg::MAP_AW-1:0] mapAddr,
  input wire logic ioUpdatePulse,
  input wire logic calStartPulse,
  input wire logic distSyncPulse,
  input wire logic busy
);
  import ncs_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Sequencer checks
  // ----------------------------------------------------------------
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !busy && !mapWrEn && !mapRdEn && !ioUpdatePulse)
    else $error("sequencer active right after reset");
  a_io_alone: assert property (
    ioUpdatePulse |-> busy && !calStartPulse && !distSyncPulse && !mapWrEn)
    else $error("update pulse outside a lone download step");
  a_cal_alone: assert property (
    calStartPulse |-> busy && !distSyncPulse && !mapRdEn && !mapWrEn)
    else $error("calibration pulse outside a lone download step");
  a_sync_alone: assert property (
    distSyncPulse |-> busy && !mapRdEn && !mapWrEn)
    else $error("sync pulse outside a lone download step");
  a_upload_quiet: assert property (
    mapRdEn |-> !(ioUpdatePulse || calStartPulse || distSyncPulse))
    else $error("download action during upload read");
  a_map_excl: assert property (
    !(mapWrEn && mapRdEn))
    else $error("map read and write at once");
  a_rd_gap: assert property (
    mapRdEn |=> !mapRdEn [*2])
    else $error("map reads closer than three cycles");
  a_rd_step: assert property (
    mapRdEn ##3 mapRdEn |-> mapAddr == $past(mapAddr, 3) + 16'h0001)
    else $error("upload read address not stepping by one");
  a_wr_step: assert property (
    mapWrEn ##1 mapWrEn |-> mapAddr == $past(mapAddr) + 16'h0001)
    else $error("download write address not stepping by one");
  a_load_start: assert property (
    regWrEn && regAddr == OFS_LOAD && regWrData[BIT_LOAD] && !busy |=> busy)
    else $error("load command did not start the sequencer");
  a_map_busy: assert property (
    mapRdEn || mapWrEn |-> busy)
    else $error("map access while idle");

endmodule : ncs_seq_monitor

bind ncs_nvm_config_sequencer ncs_seq_monitor u_mon (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .regWrEn(regWrEn),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .mapWrEn(mapWrEn),
  .mapRdEn(mapRdEn),
  .mapAddr(mapAddr),
  .ioUpdatePulse(ioUpdatePulse),
  .calStartPulse(calStartPulse),
  .distSyncPulse(distSyncPulse),
  .busy(busy)
);

// file: testbench/tb_top.sv
`timescale 1ns/100ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  import ncs_pkg::*;

  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic [4:0] condPins = 5'h00;
  logic [7:0] regRdData;
  logic mapWrEn;
  logic mapRdEn;
  logic ioUpdatePulse;
  logic calStartPulse;
  logic distSyncPulse;
  logic busy;
  logic [15:0] mapAddr;
  logic [7:0] mapWrData;
  logic [7:0] mapRdData;
  logic [7:0] rdVal;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ioCnt = 0;
  int calCnt = 0;
  int syncCnt = 0;

  ncs_nvm_config_sequencer uut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .powerUpConditionPins(condPins),
    .mapWrEn(mapWrEn),
    .mapRdEn(mapRdEn),
    .mapAddr(mapAddr),
    .mapWrData(mapWrData),
    .mapRdData(mapRdData),
    .ioUpdatePulse(ioUpdatePulse),
    .calStartPulse(calStartPulse),
    .distSyncPulse(distSyncPulse),
    .busy(busy)
  );

  ncs_map_model u_map (
    .sys_clk(sys_clk),
    .mapWrEn(mapWrEn),
    .mapRdEn(mapRdEn),
    .mapAddr(mapAddr),
    .mapWrData(mapWrData),
    .mapRdData(mapRdData)
  );

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (ioUpdatePulse === 1'b1) ioCnt++;
    if (calStartPulse === 1'b1) calCnt++;
    if (distSyncPulse === 1'b1) syncCnt++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge sys_clk) #1 regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk) #1 regRdEn = 1'b1;
    regAddr = a;
    @(posedge sys_clk) #1 regRdEn = 1'b0;
    rdVal = regRdData;
  endtask : rd

  task automatic wait_idle;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
    #1 `CHK(busy, 1'b0)
  endtask : wait_idle

  task automatic load_sp(input logic [7:0] s[$]);
    foreach (s[i]) wr(OFS_SP_FIRST + 16'(i), s[i]);
  endtask : load_sp

  task automatic upload;
    wr(OFS_WR_ENABLE, 8'h01);
    wr(OFS_SAVE, 8'h01);
    wait_idle();
  endtask : upload

  task automatic download;
    ioCnt = 0;
    calCnt = 0;
    syncCnt = 0;
    wr(OFS_LOAD, 8'h02);
    wait_idle();
  endtask : download

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_STATUS);
    `CHK(rdVal, 8'h00)
    rd(OFS_SP_FIRST);
    `CHK(rdVal, 8'hff)
    rd(16'h0e50);
    `CHK(rdVal, 8'h00)
    wr(OFS_SAVE, 8'h01);
    `CHK(busy, 1'b0)
  endtask : t_reset

  task automatic t_pause_upload;
    u_map.mem[8'h34] = 8'h5a;
    u_map.mem[8'h35] = 8'h3c;
    load_sp('{8'h01, 8'h12, 8'h34, 8'hfe});
    rd(OFS_SP_FIRST + 16'h0001);
    `CHK(rdVal, 8'h12)
    upload();
    load_sp('{8'h80, 8'ha0, 8'ha1, 8'hff});
    upload();
    `CHK(ioCnt + calCnt + syncCnt, 0)
  endtask : t_pause_upload

  task automatic t_download;
    u_map.mem[8'h34] = 8'h00;
    u_map.mem[8'h35] = 8'h00;
    download();
    `CHK(u_map.mem[8'h34], 8'h5a)
    `CHK(u_map.mem[8'h35], 8'h3c)
    `CHK(ioCnt, 1)
    `CHK(calCnt, 1)
    `CHK(syncCnt, 1)
    rd(OFS_STATUS);
    `CHK(rdVal[1:0], 2'b01)
  endtask : t_download

  task automatic t_condition;
    wr(OFS_CONDITION, 8'h02);
    load_sp('{8'hb1, 8'h80, 8'hb0, 8'ha0, 8'hff});
    upload();
    download();
    `CHK(ioCnt, 0)
    `CHK(calCnt, 1)
    wr(OFS_CONDITION, 8'h01);
    download();
    `CHK(ioCnt, 1)
    download();
    `CHK(ioCnt, 1)
  endtask : t_condition

  // Mid-run reset with nonzero pins: boot download under pin condition
  task automatic t_boot;
    condPins = 5'h02;
    ioCnt = 0;
    calCnt = 0;
    @(posedge sys_clk) #1 sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(OFS_CONDITION);
    `CHK(rdVal, 8'h00)
    repeat (3) @(posedge sys_clk);
    #1 `CHK(busy, 1'b1)
    wait_idle();
    `CHK(ioCnt, 0)
    `CHK(calCnt, 1)
    rd(OFS_STATUS);
    `CHK(rdVal[1:0], 2'b01)
  endtask : t_boot

  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_pause_upload();
    t_download();
    t_condition();
    t_boot();
    print_verdict();
  end

endmodule : tb_top
